// ===== modbus_crc16_step.sv
`timescale 1ns/1ps
// one byte of the modbus crc-16, lsb first
module modbus_crc16_step (
   input wire logic [15:0] crc_i,
   input wire logic [7:0] data_i,
   output logic [15:0] crc_o
);
   always_comb begin
      crc_o = crc_i ^ {8'h00, data_i};
      for (int b = 0; b < 8; b++) begin
         if (crc_o[0]) begin
            crc_o = (crc_o >> 1) ^ modbus_func_pkg::CRC_POLY;
         end else begin
            crc_o = crc_o >> 1;
         end
      end
   end
endmodule : modbus_crc16_step

// ===== modbus_func_pkg.sv
package modbus_func_pkg;

   typedef enum logic [3:0] {
      ST_RX    = 4'b0001,
      ST_CHECK = 4'b0010,
      ST_WRITE = 4'b0100,
      ST_TX    = 4'b1000
   } state_t;

   // function codes and answers
   localparam logic [7:0] FC_DIAG = 8'h08;
   localparam logic [7:0] FC_WRMULT = 8'h10;
   localparam logic [7:0] FC_LOG = 8'h46;
   localparam logic [7:0] EXC_FLAG = 8'h80;
   localparam logic [7:0] EXC_FUNC = 8'h01;
   localparam logic [7:0] EXC_ADDR = 8'h02;
   localparam logic [7:0] EXC_VALUE = 8'h03;
   localparam logic [7:0] BCAST_ADDR = 8'h00;
   localparam logic [15:0] DIAG_SUB_ECHO = 16'h0000;

   // frame field positions
   localparam int POS_ADDR = 0;
   localparam int POS_FC = 1;
   localparam int POS_F2 = 2;
   localparam int POS_F3 = 3;
   localparam int POS_F4 = 4;
   localparam int POS_F5 = 5;
   localparam int POS_BCNT = 6;
   localparam logic [8:0] POS_DATA = 9'h007;

   // lengths
   localparam int FRAME_DEPTH = 264;
   localparam logic [8:0] FRAME_MAX = 9'h108;
   localparam logic [8:0] MIN_FRAME = 9'h004;
   localparam logic [8:0] DIAG_LEN = 9'h008;
   localparam logic [8:0] LOG_QLEN = 9'h004;
   localparam logic [8:0] WR_HDR = 9'h009;
   localparam logic [8:0] EXC_LEN = 9'h003;
   localparam logic [8:0] RESP6_LEN = 9'h006;
   localparam logic [15:0] MAX_REGS = 16'h007d;

   // crc-16, reflected polynomial
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'ha001;
   localparam logic [15:0] CRC_GOOD = 16'h0000;

endpackage : modbus_func_pkg

// ===== modbus_master_model.sv
`timescale 1ns/1ps
// behavioural bus master plus write recorder queuing the accepted writes and answering the write port
module modbus_master_model (
   input wire logic clk_i,
   output logic [7:0] rx_byte_o,
   output logic rx_valid_o,
   output logic rx_err_o,
   output logic rx_frame_end_o,
   input wire logic [7:0] tx_byte_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   input wire logic wr_en_i,
   input wire logic [15:0] wr_addr_i,
   input wire logic [15:0] wr_data_i,
   output logic wr_ok_o
);
   logic slow = 1'b0;
   logic accept = 1'b1;
   int err_at = -1;
   logic [7:0] got[$];
   logic [15:0] wr_a[$];
   logic [15:0] wr_d[$];
   initial begin
      rx_byte_o = 8'h00;
      rx_valid_o = 1'b0;
      rx_err_o = 1'b0;
      rx_frame_end_o = 1'b0;
   end
   // bytes back to back, frame end with the last byte
   task automatic send(input logic [7:0] q[$]);
      for (int i = 0; i < q.size(); i++) begin
         @(negedge clk_i);
         rx_byte_o = q[i];
         rx_valid_o = 1'b1;
         rx_err_o = (i == err_at);
         rx_frame_end_o = (i == q.size() - 1);
      end
      @(negedge clk_i);
      // idle line shows the inverse, so a stale byte cannot pass
      rx_byte_o = ~rx_byte_o;
      rx_valid_o = 1'b0;
      rx_err_o = 1'b0;
      rx_frame_end_o = 1'b0;
   endtask : send
   always @(negedge clk_i) tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
   assign wr_ok_o = wr_en_i ? accept : ~accept;
   always @(posedge clk_i) begin
      if (tx_valid_i && tx_ready_o) got.push_back(tx_byte_i);
      if (wr_en_i && accept) begin
         wr_a.push_back(wr_addr_i);
         wr_d.push_back(wr_data_i);
      end
   end
endmodule : modbus_master_model

// ===== modbus_slave_func_handler.sv
`timescale 1ns/1ps
module modbus_slave_func_handler (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic [7:0] slave_addr_i,
   input wire logic [7:0] rx_byte_i,
   input wire logic rx_valid_i,
   input wire logic rx_err_i,
   input wire logic rx_frame_end_i,
   output logic [7:0] tx_byte_o,
   output logic tx_valid_o,
   input wire logic tx_ready_i,
   output logic wr_en_o,
   output logic [15:0] wr_addr_o,
   output logic [15:0] wr_data_o,
   input wire logic wr_ok_i
);

   typedef struct packed {
      modbus_func_pkg::state_t st;
      logic [modbus_func_pkg::FRAME_DEPTH-1:0][7:0] frm;
      logic [8:0] len;
      logic err;
      logic [15:0] rcrc;
      logic [8:0] tx_len;
      logic [8:0] pos;
      logic append;
      logic [15:0] tcrc;
      logic tx_valid;
      logic [7:0] tx_byte;
      logic [6:0] widx;
      logic bcast;
      logic wr_en;
      logic [15:0] wr_addr;
      logic [15:0] wr_data;
      logic [15:0] ok_start;
      logic [15:0] ok_cnt;
      logic [15:0] log_start;
      logic [15:0] log_cnt;
   } state_bits_t;

   state_bits_t q;
   state_bits_t next_q;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);

   logic [15:0] crc_rx_out;
   logic [15:0] crc_tx_out;
   logic [7:0] fc;
   logic [15:0] reg_start;
   logic [15:0] reg_cnt;
   logic [7:0] byte_cnt;
   logic frame_ok;
   logic to_me;
   logic is_bcast;
   logic wr_shape_ok;
   logic go_tx;
   logic go_exc;
   logic [7:0] exc_code;
   logic [8:0] nxt_pos;
   logic [8:0] data_idx;

   modbus_crc16_step crc_rx (
      .crc_i(q.rcrc),
      .data_i(rx_byte_i),
      .crc_o(crc_rx_out)
   );

   modbus_crc16_step crc_tx (
      .crc_i(q.tcrc),
      .data_i(q.tx_byte),
      .crc_o(crc_tx_out)
   );

   assign fc = q.frm[modbus_func_pkg::POS_FC];
   assign reg_start = {q.frm[modbus_func_pkg::POS_F2], q.frm[modbus_func_pkg::POS_F3]};
   assign reg_cnt = {q.frm[modbus_func_pkg::POS_F4], q.frm[modbus_func_pkg::POS_F5]};
   assign byte_cnt = q.frm[modbus_func_pkg::POS_BCNT];
   // a running crc over the whole frame including its crc ends at zero
   assign frame_ok = (q.len >= modbus_func_pkg::MIN_FRAME) && !q.err
                     && (q.rcrc == modbus_func_pkg::CRC_GOOD);
   assign to_me = q.frm[modbus_func_pkg::POS_ADDR] == slave_addr_i;
   assign is_bcast = q.frm[modbus_func_pkg::POS_ADDR] == modbus_func_pkg::BCAST_ADDR;
   assign wr_shape_ok = (reg_cnt != 16'h0000) && (reg_cnt <= modbus_func_pkg::MAX_REGS)
                        && (byte_cnt == {reg_cnt[6:0], 1'b0})
                        && (q.len == 9'(modbus_func_pkg::WR_HDR + {1'b0, byte_cnt}));
   assign data_idx = 9'(modbus_func_pkg::POS_DATA + {1'b0, q.widx, 1'b0});

   always_comb begin
      next_q = q;
      next_q.wr_en = 1'b0;
      go_tx = 1'b0;
      go_exc = 1'b0;
      exc_code = modbus_func_pkg::EXC_FUNC;
      nxt_pos = 9'(q.pos + 9'h001);
      case (q.st)
         modbus_func_pkg::ST_RX: begin
            if (rx_valid_i) begin
               // overlong frames are marked bad instead of wrapping the store
               if (q.len < modbus_func_pkg::FRAME_MAX) begin
                  next_q.frm[q.len] = rx_byte_i;
                  next_q.len = 9'(q.len + 9'h001);
               end else begin
                  next_q.err = 1'b1;
               end
               next_q.rcrc = crc_rx_out;
               if (rx_err_i) begin
                  next_q.err = 1'b1;
               end
            end
            if (rx_frame_end_i) begin
               next_q.st = modbus_func_pkg::ST_CHECK;
            end
         end
         modbus_func_pkg::ST_CHECK: begin
            next_q.st = modbus_func_pkg::ST_RX;
            next_q.len = 9'h000;
            next_q.err = 1'b0;
            next_q.rcrc = modbus_func_pkg::CRC_INIT;
            if (frame_ok && (to_me || is_bcast)) begin
               if (fc == modbus_func_pkg::FC_WRMULT) begin
                  if (wr_shape_ok) begin
                     next_q.st = modbus_func_pkg::ST_WRITE;
                     next_q.widx = 7'h00;
                     next_q.ok_cnt = 16'h0000;
                     next_q.ok_start = 16'h0000;
                     next_q.bcast = is_bcast;
                  end else begin
                     next_q.log_start = 16'h0000;
                     next_q.log_cnt = 16'h0000;
                     go_exc = !is_bcast;
                     exc_code = modbus_func_pkg::EXC_VALUE;
                  end
               end else if (is_bcast) begin
                  // address 0 is not valid for the other functions: dropped
                  next_q.st = modbus_func_pkg::ST_RX;
               end else if (fc == modbus_func_pkg::FC_DIAG) begin
                  next_q.log_start = 16'h0000;
                  next_q.log_cnt = 16'h0000;
                  if (reg_start != modbus_func_pkg::DIAG_SUB_ECHO) begin
                     go_exc = 1'b1;
                     exc_code = modbus_func_pkg::EXC_FUNC;
                  end else if (q.len != modbus_func_pkg::DIAG_LEN) begin
                     go_exc = 1'b1;
                     exc_code = modbus_func_pkg::EXC_VALUE;
                  end else begin
                     // echo the stored query verbatim, received crc included
                     go_tx = 1'b1;
                     next_q.tx_len = q.len;
                     next_q.append = 1'b0;
                  end
               end else if (fc == modbus_func_pkg::FC_LOG) begin
                  if (q.len == modbus_func_pkg::LOG_QLEN) begin
                     next_q.frm[modbus_func_pkg::POS_F2] = q.log_start[15:8];
                     next_q.frm[modbus_func_pkg::POS_F3] = q.log_start[7:0];
                     next_q.frm[modbus_func_pkg::POS_F4] = q.log_cnt[15:8];
                     next_q.frm[modbus_func_pkg::POS_F5] = q.log_cnt[7:0];
                     next_q.tx_len = modbus_func_pkg::RESP6_LEN;
                     next_q.append = 1'b1;
                     go_tx = 1'b1;
                  end else begin
                     go_exc = 1'b1;
                     exc_code = modbus_func_pkg::EXC_VALUE;
                  end
                  next_q.log_start = 16'h0000;
                  next_q.log_cnt = 16'h0000;
               end else begin
                  next_q.log_start = 16'h0000;
                  next_q.log_cnt = 16'h0000;
                  go_exc = 1'b1;
                  exc_code = modbus_func_pkg::EXC_FUNC;
               end
            end
         end
         modbus_func_pkg::ST_WRITE: begin
            if (q.wr_en && wr_ok_i) begin
               if (q.ok_cnt == 16'h0000) begin
                  next_q.ok_start = q.wr_addr;
               end
               next_q.ok_cnt = 16'(q.ok_cnt + 16'h0001);
            end
            if ({9'h000, q.widx} < reg_cnt) begin
               next_q.wr_en = 1'b1;
               next_q.wr_addr = 16'(reg_start + {9'h000, q.widx});
               next_q.wr_data = {q.frm[data_idx], q.frm[9'(data_idx + 9'h001)]};
               next_q.widx = 7'(q.widx + 7'h01);
            end else if (!q.wr_en) begin
               next_q.log_start = q.ok_start;
               next_q.log_cnt = q.ok_cnt;
               if (q.bcast) begin
                  next_q.st = modbus_func_pkg::ST_RX;
               end else if (q.ok_cnt == 16'h0000) begin
                  go_exc = 1'b1;
                  exc_code = modbus_func_pkg::EXC_ADDR;
               end else begin
                  // query start and count are still in place in the store
                  next_q.tx_len = modbus_func_pkg::RESP6_LEN;
                  next_q.append = 1'b1;
                  go_tx = 1'b1;
               end
            end
         end
         modbus_func_pkg::ST_TX: begin
            if (q.tx_valid && tx_ready_i) begin
               next_q.pos = nxt_pos;
               if (nxt_pos < q.tx_len) begin
                  next_q.tx_byte = q.frm[nxt_pos];
                  next_q.tcrc = crc_tx_out;
               end else if (q.append && (nxt_pos == q.tx_len)) begin
                  next_q.tx_byte = crc_tx_out[7:0];
                  next_q.tcrc = crc_tx_out;
               end else if (q.append && (nxt_pos == 9'(q.tx_len + 9'h001))) begin
                  next_q.tx_byte = q.tcrc[15:8];
               end else begin
                  next_q.tx_valid = 1'b0;
                  next_q.st = modbus_func_pkg::ST_RX;
               end
            end
         end
         default: begin
            next_q.st = modbus_func_pkg::ST_RX;
         end
      endcase
      if (go_exc) begin
         next_q.frm[modbus_func_pkg::POS_FC] = fc | modbus_func_pkg::EXC_FLAG;
         next_q.frm[modbus_func_pkg::POS_F2] = exc_code;
         next_q.tx_len = modbus_func_pkg::EXC_LEN;
         next_q.append = 1'b1;
      end
      if (go_tx || go_exc) begin
         next_q.st = modbus_func_pkg::ST_TX;
         next_q.pos = 9'h000;
         next_q.tcrc = modbus_func_pkg::CRC_INIT;
         next_q.tx_valid = 1'b1;
         next_q.tx_byte = q.frm[modbus_func_pkg::POS_ADDR];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         q <= '0;
         q.st <= modbus_func_pkg::ST_RX;
         q.rcrc <= modbus_func_pkg::CRC_INIT;
         q.tcrc <= modbus_func_pkg::CRC_INIT;
      end else begin
         q <= next_q;
      end
   end

   assign tx_byte_o = q.tx_byte;
   assign tx_valid_o = q.tx_valid;
   assign wr_en_o = q.wr_en;
   assign wr_addr_o = q.wr_addr;
   assign wr_data_o = q.wr_data;

   sequence s_check_good;
      q.st == modbus_func_pkg::ST_CHECK && frame_ok;
   endsequence

   sequence s_tx_start;
      q.st == modbus_func_pkg::ST_TX && q.pos == 9'h000;
   endsequence

   chk_bad_frame_silent: assert property (
      q.st == modbus_func_pkg::ST_CHECK && !frame_ok |=> q.st == modbus_func_pkg::ST_RX
   ) else $error("bad frame was acted on");

   chk_bcast_no_tx: assert property (
      $rose(tx_valid_o) |-> tx_byte_o != modbus_func_pkg::BCAST_ADDR
   ) else $error("response sent for broadcast");

   chk_diag_bcast_drop: assert property (
      s_check_good ##0 is_bcast && fc != modbus_func_pkg::FC_WRMULT
      |=> q.st == modbus_func_pkg::ST_RX
   ) else $error("broadcast diag or log not dropped");

   chk_diag_echo_len: assert property (
      s_check_good ##0 to_me && fc == modbus_func_pkg::FC_DIAG
      && reg_start == 16'h0000 && q.len == modbus_func_pkg::DIAG_LEN
      |=> s_tx_start ##0 q.tx_len == 9'h008 && !q.append && tx_valid_o
   ) else $error("diagnosis echo not started");

   chk_exc_function: assert property (
      s_check_good ##0 to_me && fc == 8'h03
      |=> q.frm[modbus_func_pkg::POS_FC] == 8'h83 && q.frm[modbus_func_pkg::POS_F2] == 8'h01
   ) else $error("illegal function exception wrong");

   chk_log_cleared: assert property (
      s_check_good ##0 to_me && fc == modbus_func_pkg::FC_DIAG
      |=> q.log_cnt == 16'h0000 && q.log_start == 16'h0000
   ) else $error("log not cleared");

   chk_log_reply: assert property (
      s_check_good ##0 to_me && fc == modbus_func_pkg::FC_LOG && q.len == 9'h004
      |=> {q.frm[4], q.frm[5]} == $past(q.log_cnt) && {q.frm[2], q.frm[3]} == $past(q.log_start)
   ) else $error("log reply fields wrong");

   chk_write_step: assert property (
      wr_en_o && $past(wr_en_o) |-> wr_addr_o == 16'($past(wr_addr_o) + 16'h0001)
   ) else $error("write addresses not ascending");

   chk_write_limit: assert property (
      q.st == modbus_func_pkg::ST_WRITE |-> {9'h000, q.widx} <= reg_cnt && reg_cnt <= 16'h007d
   ) else $error("too many writes issued");

   chk_tx_hold: assert property (
      tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o)
   ) else $error("tx byte dropped while stalled");

endmodule : modbus_slave_func_handler

// ===== test_modbus_slave_func_handler.sv
`timescale 1ns/1ps
module test_modbus_slave_func_handler;
   logic ref_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [7:0] rx_byte, tx_byte;
   logic rx_valid, rx_err, rx_frame_end, tx_valid, tx_ready;
   logic wr_en, wr_ok;
   logic [15:0] wr_addr, wr_data;
   logic [7:0] fq[$];
   logic [7:0] eq[$];
   int n_mismatch = 0;
   int check_count = 0;
   initial forever #25 ref_clk_i = ~ref_clk_i;
   modbus_slave_func_handler i_modbus_slave_func_handler (.ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i), .slave_addr_i(8'h19), .rx_byte_i(rx_byte), .rx_valid_i(rx_valid),
      .rx_err_i(rx_err), .rx_frame_end_i(rx_frame_end), .tx_byte_o(tx_byte),
      .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .wr_en_o(wr_en), .wr_addr_o(wr_addr),
      .wr_data_o(wr_data), .wr_ok_i(wr_ok));
   modbus_master_model i_modbus_master_model (.clk_i(ref_clk_i), .rx_byte_o(rx_byte),
      .rx_valid_o(rx_valid), .rx_err_o(rx_err), .rx_frame_end_o(rx_frame_end),
      .tx_byte_i(tx_byte), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .wr_en_i(wr_en),
      .wr_addr_i(wr_addr), .wr_data_i(wr_data), .wr_ok_o(wr_ok));
   task automatic close_out;
      if (n_mismatch == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : close_out
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (q[i]) begin
         c ^= {8'h00, q[i]};
         repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
      return c;
   endfunction : crc16
   // sends fq with crc, expects eq plus crc, or the query itself when echo
   task automatic xfer(input bit bad_crc, input bit echo);
      logic [15:0] c;
      int n;
      c = crc16(fq) ^ {15'h0000, bad_crc};
      fq.push_back(c[7:0]);
      fq.push_back(c[15:8]);
      if (echo) eq = fq;
      else if (eq.size() > 0) begin
         c = crc16(eq);
         eq.push_back(c[7:0]);
         eq.push_back(c[15:8]);
      end
      i_modbus_master_model.got.delete();
      i_modbus_master_model.wr_a.delete();
      i_modbus_master_model.wr_d.delete();
      i_modbus_master_model.send(fq);
      n = 0;
      while (n < 600 && !(eq.size() > 0 && i_modbus_master_model.got.size() == eq.size()
             && tx_valid === 1'b0)) begin
         @(negedge ref_clk_i);
         n++;
      end
      if (eq.size() > 0 && n == 600) begin
         check("response timeout", 16'h0001, 16'h0000);
         close_out();
      end else begin
         check("resp length", i_modbus_master_model.got.size(), eq.size());
         foreach (eq[i]) check("resp byte", i_modbus_master_model.got[i], eq[i]);
      end
   endtask : xfer
   task automatic s_diag;
      i_modbus_master_model.slow = 1'b1;
      fq = '{8'h19, 8'h08, 8'h00, 8'h00, 8'hff, 8'hff};
      xfer(0, 1);
      i_modbus_master_model.slow = 1'b0;
      fq = '{8'h19, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00};
      xfer(0, 1);
      fq = '{8'h19, 8'h08, 8'h00, 8'h01, 8'h12, 8'h34};
      eq = '{8'h19, 8'h88, 8'h01};
      xfer(0, 0);
      fq = '{8'h00, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34};
      eq = {};
      xfer(0, 0);
      // another slave's query must stay unanswered
      fq = '{8'h1a, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34};
      xfer(0, 0);
   endtask : s_diag
   task automatic s_write_log;
      fq = '{8'h19, 8'h10, 8'h03, 8'hee, 8'h00, 8'h02, 8'h04, 8'h00, 8'h05, 8'h00, 8'h0a};
      eq = '{8'h19, 8'h10, 8'h03, 8'hee, 8'h00, 8'h02};
      xfer(0, 0);
      check("writes", i_modbus_master_model.wr_a.size(), 16'h0002);
      check("wr addr0", i_modbus_master_model.wr_a[0], 16'h03ee);
      check("wr addr1", i_modbus_master_model.wr_a[1], 16'h03ef);
      check("wr data0", i_modbus_master_model.wr_d[0], 16'h0005);
      check("wr data1", i_modbus_master_model.wr_d[1], 16'h000a);
      fq = '{8'h19, 8'h46};
      eq = '{8'h19, 8'h46, 8'h03, 8'hee, 8'h00, 8'h02};
      xfer(0, 0);
      fq = '{8'h19, 8'h46};
      eq = '{8'h19, 8'h46, 8'h00, 8'h00, 8'h00, 8'h00};
      xfer(0, 0);
      fq = '{8'h00, 8'h46};
      eq = {};
      xfer(0, 0);
   endtask : s_write_log
   task automatic s_bcast;
      fq = '{8'h00, 8'h10, 8'h00, 8'h01, 8'h00, 8'h01, 8'h02, 8'hab, 8'hcd};
      eq = {};
      xfer(0, 0);
      check("bc writes", i_modbus_master_model.wr_a.size(), 16'h0001);
      check("bc addr", i_modbus_master_model.wr_a[0], 16'h0001);
      check("bc data", i_modbus_master_model.wr_d[0], 16'habcd);
      fq = '{8'h19, 8'h46};
      eq = '{8'h19, 8'h46, 8'h00, 8'h01, 8'h00, 8'h01};
      xfer(0, 0);
   endtask : s_bcast
   task automatic s_limits;
      for (int k = 125; k <= 126; k++) begin
         fq = '{8'h19, 8'h10, 8'h00, 8'h10, 8'h00, k[7:0], 8'(2 * k)};
         for (int j = 0; j < 2 * k; j++) fq.push_back(j[7:0]);
         if (k == 125) eq = '{8'h19, 8'h10, 8'h00, 8'h10, 8'h00, 8'h7d};
         else eq = '{8'h19, 8'h90, 8'h03};
         xfer(0, 0);
      end
      fq = '{8'h19, 8'h10, 8'h00, 8'h10, 8'h00, 8'h01, 8'h04, 8'h00, 8'h01, 8'h00, 8'h02};
      eq = '{8'h19, 8'h90, 8'h03};
      xfer(0, 0);
      check("no write", i_modbus_master_model.wr_a.size(), 16'h0000);
   endtask : s_limits
   task automatic s_errors;
      fq = '{8'h19, 8'h10, 8'h00, 8'h01, 8'h00, 8'h01, 8'h02, 8'h11, 8'h22};
      eq = {};
      xfer(1, 0);
      check("crc bad writes", i_modbus_master_model.wr_a.size(), 16'h0000);
      i_modbus_master_model.err_at = 3;
      fq = '{8'h19, 8'h08, 8'h00, 8'h00, 8'h55, 8'haa};
      xfer(0, 0);
      i_modbus_master_model.err_at = -1;
      fq = '{8'h19, 8'h03, 8'h00, 8'h01, 8'h00, 8'h01};
      eq = '{8'h19, 8'h83, 8'h01};
      xfer(0, 0);
      i_modbus_master_model.accept = 1'b0;
      fq = '{8'h19, 8'h10, 8'h00, 8'h01, 8'h00, 8'h01, 8'h02, 8'h11, 8'h22};
      eq = '{8'h19, 8'h90, 8'h02};
      xfer(0, 0);
      i_modbus_master_model.accept = 1'b1;
      fq = '{8'h19, 8'h46};
      eq = '{8'h19, 8'h46, 8'h00, 8'h00, 8'h00, 8'h00};
      xfer(0, 0);
   endtask : s_errors
   // reset in mid-run must drop the access log
   task automatic s_reset;
      fq = '{8'h19, 8'h10, 8'h00, 8'h20, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34};
      eq = '{8'h19, 8'h10, 8'h00, 8'h20, 8'h00, 8'h01};
      xfer(0, 0);
      rstn_i = 1'b0;
      repeat (2) @(negedge ref_clk_i);
      rstn_i = 1'b1;
      check("rst tx valid", {15'h0000, tx_valid}, 16'h0000);
      check("rst wr en", {15'h0000, wr_en}, 16'h0000);
      fq = '{8'h19, 8'h46};
      eq = '{8'h19, 8'h46, 8'h00, 8'h00, 8'h00, 8'h00};
      xfer(0, 0);
   endtask : s_reset
   initial begin
      repeat (8) @(negedge ref_clk_i);
      rstn_i = 1'b1;
      check("tx idle", {15'h0000, tx_valid}, 16'h0000);
      s_diag();
      s_write_log();
      s_bcast();
      s_limits();
      s_errors();
      s_reset();
      close_out();
   end
endmodule : test_modbus_slave_func_handler
